/* clock_and_power_mode_control.sv */
// Purpose: clock registers, prescaler, pll setup and idle/power-down control
// Assumes: mclk is the oscillator clock; sfr bus is single-cycle
// Notes:   clocks are gated, not generated, except the core enable
`include "clkpwr_consts.svh"
module clock_and_power_mode_control #(
  parameter int PLL_MULT_W = 5,
  parameter int PLL_DIV_W  = 4
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    sfr_wr,
  input  wire logic                    sfr_rd,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic [7:0]              sfr_wdata,
  output logic      [7:0]              sfr_rdata,
  output logic                         sfr_hit,
  input  wire logic                    irq_any,
  input  wire logic                    irq_enabled,
  input  wire logic                    watchdog_reset_req,
  input  wire logic                    supervisor_reset_req,
  input  wire logic                    usb_pll_clk,
  output logic                         pll_enable,
  output logic      [PLL_MULT_W-1:0]   pll_multiplier,
  output logic      [PLL_DIV_W-1:0]    pll_divider,
  output logic                         osc_enable,
  output logic                         core_clk_en,
  output logic                         core_run,
  output logic                         breakpoint_comparator_on,
  output logic                         hold_ports,
  output logic                         watchdog_reset_out,
  output logic                         core_reset,
  output clkpwr_pkg::power_mode_e      power_mode,
  output logic                         peripheral_clock,
  output logic                         usb_clock
);
  import clkpwr_pkg::*;

  logic        rst_meta;
  logic        rst_sync_n;
  logic [7:0]  clock_control_reg;
  logic [7:0]  pll_control_reg;
  logic        idle_request_bit;
  logic        powerdown_request_bit;
  logic        sup_meta;
  logic        sup_sync;
  logic        wdt_meta;
  logic        wdt_sync;
  logic [1:0]  restart_cnt;
  logic [1:0]  mc_cnt;
  logic [10:0] pre_cnt;
  logic [10:0] pre_mask;
  logic        usb_gate_en;
  logic        periph_gate_en;
  power_mode_e next_mode;
  prescale_t   core_clock_prescale;
  logic        auto_speed_recovery;
  logic        wr_clock_control;
  logic        wr_pll_control;
  logic        wr_power_control;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // external reset sources synchronised
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
      wdt_meta <= 1'b0;
      wdt_sync <= 1'b0;
    end else begin
      sup_meta <= supervisor_reset_req;
      sup_sync <= sup_meta;
      wdt_meta <= watchdog_reset_req;
      wdt_sync <= wdt_meta;
    end
  end

  assign wr_clock_control = sfr_wr && (sfr_addr == `CLOCK_CONTROL_ADDR);
  assign wr_pll_control   = sfr_wr && (sfr_addr == `PLL_CONTROL_ADDR);
  assign wr_power_control = sfr_wr && (sfr_addr == `POWER_CONTROL_ADDR);
  assign core_clock_prescale = clock_control_reg[2:0];
  assign auto_speed_recovery = clock_control_reg[`BIT_AUTO_RECOVER];

  // clock control register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_control_reg <= `CLOCK_CONTROL_RESET;
    end else if (sup_sync) begin
      clock_control_reg <= `CLOCK_CONTROL_RESET;
    end else begin
      if (wr_clock_control)
        clock_control_reg <= sfr_wdata;
      if (irq_any && auto_speed_recovery && !(wr_clock_control && !sfr_wdata[`BIT_AUTO_RECOVER]))
        clock_control_reg[2:0] <= 3'h0;
    end
  end

  // pll control register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_control_reg <= `PLL_CONTROL_RESET;
    end else if (sup_sync) begin
      pll_control_reg <= `PLL_CONTROL_RESET;
    end else if (wr_pll_control) begin
      pll_control_reg <= sfr_wdata;
    end
  end

  // power control bits, hardware clear by supervisor reset, idle bit also by enabled interrupt
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      idle_request_bit      <= 1'b0;
      powerdown_request_bit <= 1'b0;
    end else if (sup_sync) begin
      idle_request_bit      <= 1'b0;
      powerdown_request_bit <= 1'b0;
    end else begin
      if (wr_power_control && sfr_wdata[`IDLE_BIT])
        idle_request_bit <= 1'b1;
      else if (irq_enabled)
        idle_request_bit <= 1'b0;
      if (wr_power_control && sfr_wdata[`PD_BIT])
        powerdown_request_bit <= 1'b1;
    end
  end

  // mode state
  always_comb begin
    next_mode = power_mode;
    case (power_mode)
      MODE_RUN: begin
        if (wr_power_control && sfr_wdata[`PD_BIT])
          next_mode = MODE_PDOWN;
        else if (wr_power_control && sfr_wdata[`IDLE_BIT])
          next_mode = MODE_IDLE;
      end
      MODE_IDLE: begin
        if (sup_sync)
          next_mode = MODE_RSTRT;
        else if (irq_enabled)
          next_mode = MODE_RUN;
      end
      MODE_PDOWN: begin
        if (sup_sync)
          next_mode = MODE_RSTRT;
      end
      MODE_RSTRT: begin
        if (restart_cnt == 2'(`SUPV_RESTART_CYCLES - 1) && mc_cnt == 2'(`MACHINE_CYCLE_CLKS - 1))
          next_mode = MODE_RUN;
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      power_mode <= MODE_RUN;
    else
      power_mode <= next_mode;
  end

  // machine cycle counter for restart delay
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mc_cnt      <= 2'h0;
      restart_cnt <= 2'h0;
    end else if (power_mode != MODE_RSTRT) begin
      mc_cnt      <= 2'h0;
      restart_cnt <= 2'h0;
    end else begin
      mc_cnt <= mc_cnt + 2'h1;
      if (mc_cnt == 2'(`MACHINE_CYCLE_CLKS - 1))
        restart_cnt <= restart_cnt + 2'h1;
    end
  end

  // prescaler: mask selects divisor, takes effect next edge
  always_comb begin
    case (core_clock_prescale)
      3'h0:    pre_mask = 11'h000;
      3'h1:    pre_mask = 11'h001;
      3'h2:    pre_mask = 11'h003;
      3'h3:    pre_mask = 11'h007;
      3'h4:    pre_mask = 11'h00f;
      3'h5:    pre_mask = 11'h01f;
      3'h6:    pre_mask = 11'h3ff;
      3'h7:    pre_mask = 11'h7ff;
      default: pre_mask = 11'h000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      pre_cnt <= 11'h000;
    else if (wr_clock_control || (pre_cnt & pre_mask) == pre_mask)
      pre_cnt <= 11'h000;
    else
      pre_cnt <= pre_cnt + 11'h001;
  end

  // core enable pulse, blocked in idle and power-down
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_clk_en <= 1'b0;
      core_run    <= 1'b0;
      hold_ports  <= 1'b0;
      core_reset  <= 1'b1;
    end else begin
      core_clk_en <= (next_mode == MODE_RUN) && ((pre_cnt & pre_mask) == pre_mask);
      core_run    <= (next_mode == MODE_RUN);
      hold_ports  <= (next_mode == MODE_IDLE) || (next_mode == MODE_PDOWN);
      core_reset  <= (next_mode == MODE_RSTRT);
    end
  end

  // analog and debug controls
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_enable               <= 1'b1;
      pll_multiplier           <= '0;
      pll_divider              <= '0;
      osc_enable               <= 1'b1;
      breakpoint_comparator_on <= 1'b1;
      watchdog_reset_out       <= 1'b0;
      usb_gate_en              <= 1'b0;
      periph_gate_en           <= 1'b1;
    end else begin
      pll_enable     <= clock_control_reg[`BIT_PLL_ON] && (next_mode != MODE_PDOWN);
      pll_multiplier <= {clock_control_reg[`BIT_PLL_MULT_TOP], pll_control_reg[7:4]};
      pll_divider    <= pll_control_reg[3:0];
      osc_enable     <= (next_mode != MODE_PDOWN);
      breakpoint_comparator_on <= clock_control_reg[`BIT_BKPT_ON];
      watchdog_reset_out <= wdt_sync && (power_mode == MODE_RUN);
      usb_gate_en    <= clock_control_reg[`BIT_USB_GATE] && (next_mode != MODE_PDOWN);
      periph_gate_en <= (next_mode != MODE_PDOWN);
    end
  end

  // register read
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_hit <= sfr_rd && (sfr_addr == `CLOCK_CONTROL_ADDR || sfr_addr == `PLL_CONTROL_ADDR
                 || sfr_addr == `POWER_CONTROL_ADDR);
      if (!sfr_rd)
        sfr_rdata <= 8'h00;
      else if (sfr_addr == `CLOCK_CONTROL_ADDR)
        sfr_rdata <= clock_control_reg;
      else if (sfr_addr == `PLL_CONTROL_ADDR)
        sfr_rdata <= pll_control_reg;
      else if (sfr_addr == `POWER_CONTROL_ADDR)
        sfr_rdata <= {6'h00, powerdown_request_bit, idle_request_bit};
      else
        sfr_rdata <= 8'h00;
    end
  end

  // glitch free gating of output clocks
  clock_gate u_periph_gate (
    .clk_in  (mclk),
    .enable  (periph_gate_en),
    .clk_out (peripheral_clock)
  );

  clock_gate u_usb_gate (
    .clk_in  (usb_pll_clk),
    .enable  (usb_gate_en),
    .clk_out (usb_clock)
  );
endmodule

/* clkpwr_consts.svh */
`ifndef CLKPWR_CONSTS_SVH
`define CLKPWR_CONSTS_SVH
`define CLOCK_CONTROL_ADDR  8'hf9
`define PLL_CONTROL_ADDR    8'hfa
`define POWER_CONTROL_ADDR  8'h87
`define CLOCK_CONTROL_RESET 8'h50
`define PLL_CONTROL_RESET   8'h00
`define BIT_PLL_MULT_TOP    7
`define BIT_PLL_ON          6
`define BIT_USB_GATE        5
`define BIT_BKPT_ON         4
`define BIT_AUTO_RECOVER    3
`define PD_BIT              1
`define IDLE_BIT            0
`define SUPV_RESTART_CYCLES 3
`define MACHINE_CYCLE_CLKS  4
`endif

/* clkpwr_pkg.sv */
// Purpose: types for clock and power mode control
// Assumes: nothing
// Notes:   mode enum shared with the bench
package clkpwr_pkg;
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_IDLE  = 2'b01,
    MODE_PDOWN = 2'b10,
    MODE_RSTRT = 2'b11
  } power_mode_e;
  typedef logic [2:0] prescale_t;
endpackage

/* clock_gate.sv */
// Purpose: glitch free clock gate
// Assumes: enable launched from clk_in domain
// Notes:   latch transparent while clk_in low
module clock_gate (
  input  wire logic clk_in,
  input  wire logic enable,
  output logic      clk_out
);
  logic en_latched;
  always_latch begin
    if (!clk_in)
      en_latched <= enable;
  end
  assign clk_out = clk_in & en_latched;
endmodule

/* clkpwr_props.sv */
// Purpose: port checker for clock and power mode control
// Assumes: sees top module ports only
// Notes:   bound after the module
`include "clkpwr_consts.svh"
module clkpwr_props
  import clkpwr_pkg::*;
#(
  parameter int PLL_MULT_W = 5,
  parameter int PLL_DIV_W  = 4
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 sfr_wr,
  input wire logic                 sfr_rd,
  input wire logic [7:0]           sfr_addr,
  input wire logic [7:0]           sfr_rdata,
  input wire logic                 sfr_hit,
  input wire logic                 irq_enabled,
  input wire logic                 pll_enable,
  input wire logic                 osc_enable,
  input wire logic                 core_clk_en,
  input wire logic                 core_run,
  input wire logic                 hold_ports,
  input wire logic                 breakpoint_comparator_on,
  input wire logic                 watchdog_reset_out,
  input wire logic                 core_reset,
  input wire power_mode_e          power_mode,
  input wire logic [PLL_DIV_W-1:0] pll_divider
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pd_clocks_off_a: assert property ((power_mode == MODE_PDOWN)[*2] |-> !pll_enable && !osc_enable)
    else $error("pll or oscillator on in power-down");
  idle_core_stop_a: assert property (power_mode == MODE_IDLE |-> !core_clk_en && !core_run && hold_ports)
    else $error("core not stopped in idle");
  idle_irq_exit_a: assert property (power_mode == MODE_IDLE && irq_enabled && !sfr_wr |=> power_mode != MODE_IDLE)
    else $error("idle kept after enabled interrupt");
  watchdog_block_a: assert property ((power_mode != MODE_RUN)[*2] |-> !watchdog_reset_out)
    else $error("watchdog reset out of run mode");
  pd_exit_path_a: assert property ($past(power_mode) == MODE_PDOWN && power_mode != MODE_PDOWN |-> power_mode == MODE_RSTRT)
    else $error("power-down left without supervisor reset");
  restart_len_a: assert property (power_mode == MODE_RSTRT && $past(power_mode) != MODE_RSTRT |-> (core_reset && power_mode == MODE_RSTRT)[*8] ##1 (core_reset && power_mode == MODE_RSTRT)[*4] ##1 power_mode == MODE_RUN)
    else $error("restart window not twelve cycles");
  unmapped_read_a: assert property (sfr_rd && !(sfr_addr inside {`CLOCK_CONTROL_ADDR, `PLL_CONTROL_ADDR, `POWER_CONTROL_ADDR}) |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  divider_match_a: assert property (sfr_rd && !sfr_wr && sfr_addr == `PLL_CONTROL_ADDR |=> sfr_hit && sfr_rdata[3:0] == pll_divider)
    else $error("divider output differs from register");
  control_bits_a: assert property (sfr_rd && !sfr_wr && core_run && sfr_addr == `CLOCK_CONTROL_ADDR |=> !core_run || (sfr_rdata[6] == pll_enable && sfr_rdata[4] == breakpoint_comparator_on))
    else $error("control outputs differ from register");
  cover property (power_mode == MODE_IDLE);
  cover property (power_mode == MODE_PDOWN);
  cover property (power_mode == MODE_RSTRT);
endmodule
bind clock_and_power_mode_control clkpwr_props #(.PLL_MULT_W(PLL_MULT_W), .PLL_DIV_W(PLL_DIV_W)) u_props (.*);

/* clock_and_power_mode_control_tb.sv */
// Purpose: bench for clock and power mode control
// Assumes: inputs change on falling mclk
// Notes:   gated clocks judged by edge counts
`include "clkpwr_consts.svh"
module clock_and_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clkpwr_pkg::*;
  logic mclk, rst_n, sfr_wr, sfr_rd, sfr_hit, irq_any, irq_enabled, pll_enable;
  logic watchdog_reset_req, supervisor_reset_req, osc_enable, core_clk_en, core_run;
  logic breakpoint_comparator_on, hold_ports, watchdog_reset_out, core_reset;
  logic peripheral_clock, usb_clock;
  logic usb_pll_clk = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [4:0] pll_multiplier;
  logic [3:0] pll_divider;
  power_mode_e power_mode, m;
  int err_total, checks_done, pc, uc, ce;
  int sh[8] = '{0, 1, 2, 3, 4, 5, 10, 11};
  clock_and_power_mode_control u_dut (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always #11 usb_pll_clk = ~usb_pll_clk;
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk) sfr_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    chk("rdata", e, sfr_rdata);
    chk("hit", h, sfr_hit);
    sfr_rd = 1'b0;
    @(negedge mclk);
  endtask
  task automatic run(input int n);
    logic p, u;
    {pc, uc, ce} = '0;
    p = peripheral_clock;
    u = usb_clock;
    for (int k = 1; k <= n * 10; k++) begin
      #1;
      pc += int'(peripheral_clock !== p);
      uc += int'(usb_clock !== u);
      p = peripheral_clock;
      u = usb_clock;
      if (k % 10 == 0) ce += int'(core_clk_en === 1'b1);
    end
  endtask
  task automatic wait_mode(input power_mode_e w);
    int k;
    k = 0;
    while (power_mode !== w && k < 40) begin
      @(negedge mclk);
      k++;
    end
    chk("mode", w, power_mode);
    if (k == 40) end_of_test();
  endtask
  task automatic pulse_irq(input logic any);
    irq_any = any;
    irq_enabled = !any;
    @(negedge mclk);
    {irq_any, irq_enabled} = 2'b00;
  endtask
  initial begin
    {rst_n, sfr_wr, sfr_rd, irq_any, irq_enabled} = '0;
    {watchdog_reset_req, supervisor_reset_req, sfr_addr, sfr_wdata} = '0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(`CLOCK_CONTROL_ADDR, `CLOCK_CONTROL_RESET, 1);
    rd(`PLL_CONTROL_ADDR, `PLL_CONTROL_RESET, 1);
    rd(`POWER_CONTROL_ADDR, 8'h00, 1);
    rd(8'h10, 8'h00, 0);
    $display("test reset values done");
    wr(`PLL_CONTROL_ADDR, 8'ha5);
    run(20000);
    wr(`CLOCK_CONTROL_ADDR, 8'hf0);
    run(20);
    chk("multiplier", 16'h1a, pll_multiplier);
    chk("divider", 16'h5, pll_divider);
    chk("usb on", 1, uc > 10);
    wr(`CLOCK_CONTROL_ADDR, 8'h00);
    run(2);
    run(20);
    chk("usb off", 0, uc);
    chk("pll bkpt", 0, {pll_enable, breakpoint_comparator_on});
    $display("test pll fields done");
    for (int c = 0; c < 8; c++) begin
      wr(`CLOCK_CONTROL_ADDR, 8'h58 | c[7:0]);
      run(2048);
      chk("core rate", 16'(2048 >> sh[c]), 16'(ce));
      chk("periph rate", 16'd4096, 16'(pc));
    end
    pulse_irq(1'b1);
    rd(`CLOCK_CONTROL_ADDR, 8'h58, 1);
    wr(`CLOCK_CONTROL_ADDR, 8'h53);
    pulse_irq(1'b1);
    rd(`CLOCK_CONTROL_ADDR, 8'h53, 1);
    $display("test prescaler done");
    for (int k = 0; k < 2; k++) begin
      m = k ? MODE_PDOWN : MODE_IDLE;
      wr(`POWER_CONTROL_ADDR, {6'h0, m});
      run(3);
      chk("mode", m, power_mode);
      chk("core hold", 16'h1, {core_clk_en, core_run, hold_ports});
      chk("osc pll", k ? 0 : 3, {osc_enable, pll_enable});
      watchdog_reset_req = 1'b1;
      run(20);
      watchdog_reset_req = 1'b0;
      chk("periph", k ? 0 : 40, pc);
      chk("watchdog", 0, watchdog_reset_out);
      pulse_irq(1'b0);
      run(2);
      chk("after irq", k ? MODE_PDOWN : MODE_RUN, power_mode);
      if (!k) wr(`POWER_CONTROL_ADDR, 8'h01);
      supervisor_reset_req = 1'b1;
      run(3);
      supervisor_reset_req = 1'b0;
      wait_mode(MODE_RSTRT);
      chk("core reset", 1, core_reset);
      wait_mode(MODE_RUN);
      rd(`CLOCK_CONTROL_ADDR, `CLOCK_CONTROL_RESET, 1);
      rd(`POWER_CONTROL_ADDR, 8'h00, 1);
      $display("test low power mode %0d done", k);
    end
    end_of_test();
  end
endmodule
